// ### tb/clkgen_asserts.sv
`timescale 1ns/100ps
module clkgen_asserts (
  // system
  input wire logic CLK,
  input wire logic SYS_RST,
  // bus
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic AVS_WAITREQUEST,
  // clocks and pll
  input wire logic MCK_EN,
  input wire logic [31:0] PERIPH_CLK_EN,
  input wire logic PLL_ON,
  input wire logic PLL_HIGH_RANGE,
  input wire logic PLL_LOCKED,
  // pin and interrupt
  input wire logic CLK_OUT_OE_N,
  input wire logic IRQ
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  // ----
  // helper
  // ----
  // saturating count, so a fourth change cannot wrap back to a legal value
  logic [1:0] n_chg_r;
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      n_chg_r <= 2'h0;
    end else if ($changed(PLL_HIGH_RANGE) && n_chg_r != 2'h3) begin
      n_chg_r <= n_chg_r + 2'h1;
    end
  end
  // ----
  // properties
  // ----
  wait_one_a: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
    else $error("waitrequest low longer than one cycle");
  bus_answer_a: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
    else $error("request not answered next cycle");
  range_once_a: assert property (n_chg_r < 2'h2)
    else $error("range bit changed twice");
  unused_off_a: assert property ((PERIPH_CLK_EN & ~32'h0000_6ffc) == 32'h0)
    else $error("unused peripheral enable active");
  periph_tick_a: assert property (|PERIPH_CLK_EN |-> MCK_EN)
    else $error("peripheral tick without master tick");
  lock_needs_pll_a: assert property ($rose(PLL_LOCKED) |-> PLL_ON)
    else $error("lock with pll off");
  pll_off_a: assert property ($fell(PLL_ON) |-> ##[0:3] !PLL_LOCKED)
    else $error("lock kept after pll off");
  irq_drop_a: assert property ($fell(IRQ) |-> $past(AVS_WRITE) || $past(AVS_WRITE, 2) ||
    $past(AVS_WRITE, 3))
    else $error("irq dropped without write");
  // the pin floats during reset and is driven from the reset mode value just after it
  oe_write_a: assert property ($changed(CLK_OUT_OE_N) && !$past(SYS_RST, 2) |-> $past(AVS_WRITE) ||
    $past(AVS_WRITE, 2))
    else $error("pin enable changed without write");
endmodule // clkgen_asserts

// ### tb/clock_gen_and_peripheral_gating_bench.sv
`timescale 1ns/100ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin n_mismatch++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module clock_gen_and_peripheral_gating_bench;
  logic clk, sys_rst, rd, wr, slow_clk, mck_en, pll_on, pll_high, pll_locked;
  logic clk_o, oe_n, irq, wait_req, lastv;
  logic [7:0] addr;
  logic [3:0] be;
  logic [31:0] wdata, rdata, periph_en, state_m, r, e_m;
  logic [31:0] exp_q[$];
  int n_mismatch, tests_run, cyc, seed, n, m, p2, p3, t;
  logic [7:0] rw[4] = '{8'h98, 8'hb9, 8'haa, 8'h08};
  int em[4] = '{16, 8, 4, 4};
  int et[4] = '{16, 4, 4, 8};

  clkgen i_dut (.CLK(clk), .SYS_RST(sys_rst), .AVS_ADDRESS(addr), .AVS_READ(rd),
    .AVS_WRITE(wr), .AVS_BYTEENABLE(be), .AVS_WRITEDATA(wdata), .AVS_READDATA(rdata),
    .AVS_WAITREQUEST(wait_req), .SLOW_CLK(slow_clk), .MCK_EN(mck_en), .PERIPH_CLK_EN(periph_en),
    .PLL_ON(pll_on), .PLL_HIGH_RANGE(pll_high), .PLL_LOCKED(pll_locked), .CLK_OUT_O(clk_o),
    .CLK_OUT_OE_N(oe_n), .IRQ(irq));
  // ----
  // clocks, timeout, read monitor
  // ----
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  // slow clock near 32768 hz: 1526 cycles per half period
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc % 1526 == 0) slow_clk <= !slow_clk;
    if (cyc == 90000) begin
      n_mismatch++;
      results();
    end
  end
  always @(posedge clk) begin
    if (rd && wait_req === 1'b0) begin
      e_m = exp_q.pop_front();
      `CHK(rdata, e_m)
    end
  end
  task automatic results();
    if (n_mismatch == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // request held until waitrequest is sampled low, then a few edges so outputs settle
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    while (wait_req !== 1'b0 && k < 100) begin
      @(posedge clk);
      k++;
    end
    if (k == 100) n_mismatch++;
    rd <= 0;
    wr <= 0;
    repeat (3) @(posedge clk);
  endtask
  task automatic rdx(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask
  function automatic logic near(input int a, input int b);
    return (a - b <= 1) && (b - a <= 1);
  endfunction
  // ----
  // scenarios
  // ----
  initial begin
    seed = 32'h1c0b;
    {rd, wr, slow_clk, addr, wdata, n_mismatch, tests_run, cyc} = '0;
    be = 4'hf;
    sys_rst = 1;
    repeat (6) @(posedge clk);
    sys_rst <= 0;
    @(posedge clk);
    rdx(8'h1c, 32'h0);
    rdx(8'h20, 32'h0);
    rdx(8'h30, 32'h0);
    rdx(8'h14, 32'h0);
    rdx(8'h08, 32'h0);
    `CHK(oe_n, 1'b0)
    state_m = 0;
    for (int i = 0; i < 6; i++) begin
      r = $random(seed);
      bus(1'b1, 8'h10, r);
      state_m = state_m | (r & 32'h0000_6ffc);
      r = $random(seed);
      bus(1'b1, 8'h14, r);
      state_m = state_m & ~r;
      rdx(8'h1c, state_m);
    end
    bus(1'b1, 8'h14, 32'hffff_ffff);
    bus(1'b1, 8'h10, 32'h0000_0004);
    rdx(8'h1c, 32'h0000_0004);
    bus(1'b1, 8'h20, 32'h0000_0008);
    rdx(8'h20, 32'h0000_0008);
    bus(1'b1, 8'h20, 32'h0000_0000);
    rdx(8'h20, 32'h0000_0008);
    `CHK(pll_high, 1'b1)
    // lane 0 only: upper lanes keep their value, the frozen range bit stays set
    be <= 4'h1;
    bus(1'b1, 8'h20, 32'hffff_fff7);
    be <= 4'hf;
    rdx(8'h20, 32'h0000_00ff);
    bus(1'b1, 8'h34, 32'h1);
    rdx(8'h3c, 32'h1);
    bus(1'b1, 8'h20, 32'h0200_0308);
    n = 0;
    while (pll_locked !== 1'b1 && n < 12000) begin
      @(posedge clk);
      n++;
    end
    `CHK(n > 3000 && n < 6200, 1'b1)
    rdx(8'h30, 32'h1);
    rdx(8'h40, 32'h1);
    `CHK(irq, 1'b1)
    bus(1'b1, 8'h38, 32'h1);
    `CHK(irq, 1'b0)
    bus(1'b1, 8'h34, 32'h1);
    `CHK(irq, 1'b1)
    bus(1'b1, 8'h44, 32'h1);
    `CHK(irq, 1'b0)
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, 8'h20, 32'h0200_0300 | rw[i]);
      rdx(8'h20, 32'h0200_0300 | rw[i]);
      repeat (3100) @(posedge clk);
      {m, p2, p3, t} = '0;
      lastv = clk_o;
      repeat (12208) begin
        @(posedge clk);
        m += mck_en;
        p2 += periph_en[2];
        p3 += periph_en[3];
        t += (clk_o !== lastv);
        lastv = clk_o;
      end
      `CHK(near(m, em[i]), 1'b1)
      `CHK(p2 == m && p3 == 0, 1'b1)
      `CHK(near(t, et[i]), 1'b1)
      `CHK(oe_n, 1'b0)
    end
    bus(1'b1, 8'h20, 32'h0200_0348);
    `CHK(oe_n, 1'b1)
    bus(1'b1, 8'h20, 32'h0000_0008);
    `CHK(pll_on, 1'b0)
    rdx(8'h30, 32'h0);
    bus(1'b1, 8'h20, 32'h0200_0308);
    `CHK(pll_on, 1'b1)
    rdx(8'h30, 32'h0);
    results();
  end
endmodule // clock_gen_and_peripheral_gating_bench

bind clkgen clkgen_asserts i_chk (.CLK(CLK), .SYS_RST(SYS_RST), .AVS_READ(AVS_READ),
  .AVS_WRITE(AVS_WRITE), .AVS_WAITREQUEST(AVS_WAITREQUEST), .MCK_EN(MCK_EN),
  .PERIPH_CLK_EN(PERIPH_CLK_EN), .PLL_ON(PLL_ON), .PLL_HIGH_RANGE(PLL_HIGH_RANGE),
  .PLL_LOCKED(PLL_LOCKED), .CLK_OUT_OE_N(CLK_OUT_OE_N), .IRQ(IRQ));

// ### verilog/clkgen.sv
// Decided for this implementation: the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`include "clkgen_map.svh"
module clkgen #(
  parameter int PER_W = 16
) (
  // system
  input wire logic CLK,
  input wire logic SYS_RST,
  // avalon-mm slave
  input wire logic [7:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [3:0] AVS_BYTEENABLE,
  input wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  // slow clock pin
  input wire logic SLOW_CLK,
  // clock enables toward peripherals and system
  output logic MCK_EN,
  output logic [31:0] PERIPH_CLK_EN,
  // pll control
  output logic PLL_ON,
  output logic PLL_HIGH_RANGE,
  output logic PLL_LOCKED,
  // clock output pin, oe low while driving
  output logic CLK_OUT_O,
  output logic CLK_OUT_OE_N,
  // interrupt
  output logic IRQ
);

  // ----------------------------------------------------------------
  // bus handshake
  // ----------------------------------------------------------------
  logic wait_r;
  logic [31:0] rdata_r;
  logic req;
  logic take;
  logic wr_take;
  logic [31:0] be_mask;
  logic [31:0] wdata;

  assign req = AVS_READ | AVS_WRITE;
  // a request is taken at the edge where waitrequest is seen low
  assign take = req & ~wait_r;
  assign wr_take = take & AVS_WRITE;
  assign be_mask = {{8{AVS_BYTEENABLE[3]}}, {8{AVS_BYTEENABLE[2]}},
                    {8{AVS_BYTEENABLE[1]}}, {8{AVS_BYTEENABLE[0]}}};
  assign wdata = AVS_WRITEDATA & be_mask;

  // one wait cycle gives the read mux a full cycle to settle
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      wait_r <= 1'b1;
    end else if (req && wait_r) begin
      wait_r <= 1'b0;
    end else begin
      wait_r <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // slow clock synchroniser
  // ----------------------------------------------------------------
  logic [2:0] slow_sync_r;
  logic slow_lvl_r;
  logic slow_tick;

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      slow_sync_r <= 3'h0;
    end else begin
      slow_sync_r <= {slow_sync_r[1:0], SLOW_CLK};
    end
  end

  // a level change counts only when the second and third stages agree
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      slow_lvl_r <= 1'b0;
    end else if (slow_sync_r[1] == slow_sync_r[2]) begin
      slow_lvl_r <= slow_sync_r[2];
    end
  end

  assign slow_tick = (slow_sync_r[1] == slow_sync_r[2]) & slow_sync_r[2] & ~slow_lvl_r;

  // ----------------------------------------------------------------
  // mode register
  // ----------------------------------------------------------------
  clkgen_pkg::mode_s mode_r;
  clkgen_pkg::mode_s mode_wr;
  logic range_set_r;
  logic restart_r;

  assign mode_wr = clkgen_pkg::mode_s'(((mode_r & ~be_mask) | wdata) & `MODE_VALID);

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      mode_r <= clkgen_pkg::mode_s'(`MODE_RESET);
      range_set_r <= 1'b0;
    end else if (wr_take && AVS_ADDRESS == `OFS_MODE) begin
      mode_r.lock_count <= mode_wr.lock_count;
      mode_r.mul <= mode_wr.mul;
      mode_r.master_clock_source <= mode_wr.master_clock_source;
      mode_r.out_dis <= mode_wr.out_dis;
      mode_r.out_src <= mode_wr.out_src;
      mode_r.prescaler_select <= mode_wr.prescaler_select;
      // the range bit is frozen after its first write
      if (!range_set_r && AVS_BYTEENABLE[0]) begin
        mode_r.range <= mode_wr.range;
        range_set_r <= 1'b1;
      end
    end
  end

  // restart the lock timer on a changed nonzero multiplier or count
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      restart_r <= 1'b0;
    end else begin
      restart_r <= wr_take && AVS_ADDRESS == `OFS_MODE && mode_wr.mul != 11'h000 &&
                   (mode_wr.mul != mode_r.mul ||
                    mode_wr.lock_count != mode_r.lock_count);
    end
  end

  // ----------------------------------------------------------------
  // lock timer
  // ----------------------------------------------------------------
  clkgen_pkg::lock_e lock_st_r;
  logic [7:0] lock_cnt_r;
  logic lock_evt;

  assign lock_evt = (lock_st_r == clkgen_pkg::LK_COUNT) && lock_cnt_r == 8'h00 &&
                    mode_r.mul != 11'h000 && !restart_r;

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      lock_st_r <= clkgen_pkg::LK_OFF;
      lock_cnt_r <= 8'h00;
    end else if (mode_r.mul == 11'h000) begin
      lock_st_r <= clkgen_pkg::LK_OFF;
      lock_cnt_r <= 8'h00;
    end else if (restart_r) begin
      lock_st_r <= clkgen_pkg::LK_COUNT;
      lock_cnt_r <= mode_r.lock_count;
    end else begin
      case (lock_st_r)
        clkgen_pkg::LK_OFF: begin
          lock_st_r <= clkgen_pkg::LK_COUNT;
          lock_cnt_r <= mode_r.lock_count;
        end
        clkgen_pkg::LK_COUNT: begin
          if (lock_cnt_r == 8'h00) begin
            lock_st_r <= clkgen_pkg::LK_DONE;
          end else if (slow_tick) begin
            lock_cnt_r <= lock_cnt_r - 8'h01;
          end
        end
        clkgen_pkg::LK_DONE: begin
          lock_st_r <= clkgen_pkg::LK_DONE;
        end
        default: begin
          lock_st_r <= clkgen_pkg::LK_OFF;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // pll model: rate follows the measured slow clock period
  // ----------------------------------------------------------------
  logic [PER_W-1:0] per_cnt_r;
  logic [PER_W-1:0] per_r;
  logic [PER_W:0] acc_r;
  logic [PER_W:0] acc_sum;
  logic pll_tick;
  logic pll_locked;

  assign pll_locked = lock_st_r == clkgen_pkg::LK_DONE;

  // period in system cycles, measured between slow clock rises
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      per_cnt_r <= '0;
      per_r <= '0;
    end else if (slow_tick) begin
      per_cnt_r <= '0;
      per_r <= per_cnt_r + PER_W'(1);
    end else if (per_cnt_r != '1) begin
      per_cnt_r <= per_cnt_r + PER_W'(1);
    end
  end

  // phase accumulator gives mul plus one ticks per slow period
  assign acc_sum = acc_r + (PER_W+1)'({1'b0, mode_r.mul} + 12'h001);
  assign pll_tick = pll_locked && per_r != '0 && acc_sum >= {1'b0, per_r};

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      acc_r <= '0;
    end else if (!pll_locked || per_r == '0) begin
      acc_r <= '0;
    end else if (pll_tick) begin
      acc_r <= acc_sum - {1'b0, per_r};
    end else begin
      acc_r <= acc_sum;
    end
  end

  // ----------------------------------------------------------------
  // source select and prescaler
  // ----------------------------------------------------------------
  logic src_tick;
  logic [5:0] prescaler_select_cnt_r;
  logic [5:0] prescaler_select_mask;
  logic mck_tick;

  assign src_tick = mode_r.master_clock_source ? pll_tick : slow_tick;

  // reserved code 7 is treated as a bypass
  always_comb begin
    case (mode_r.prescaler_select)
      3'h1: prescaler_select_mask = 6'h01;
      3'h2: prescaler_select_mask = 6'h03;
      3'h3: prescaler_select_mask = 6'h07;
      3'h4: prescaler_select_mask = 6'h0f;
      3'h5: prescaler_select_mask = 6'h1f;
      3'h6: prescaler_select_mask = 6'h3f;
      default: prescaler_select_mask = 6'h00;
    endcase
  end

  assign mck_tick = src_tick && (prescaler_select_cnt_r & prescaler_select_mask) == prescaler_select_mask;

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      prescaler_select_cnt_r <= 6'h00;
    end else if (src_tick) begin
      prescaler_select_cnt_r <= prescaler_select_cnt_r + 6'h01;
    end
  end

  // ----------------------------------------------------------------
  // clock output pin
  // ----------------------------------------------------------------
  logic mck_lvl_r;
  logic mck_half_r;
  logic out_nxt;

  // master clock waveform toggles per tick, so it runs at half the tick rate
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      mck_lvl_r <= 1'b0;
      mck_half_r <= 1'b0;
    end else if (mck_tick) begin
      mck_lvl_r <= ~mck_lvl_r;
      if (!mck_lvl_r) begin
        mck_half_r <= ~mck_half_r;
      end
    end
  end

  always_comb begin
    case (clkgen_pkg::out_src_e'(mode_r.out_src))
      clkgen_pkg::OUT_SLOW: out_nxt = slow_lvl_r;
      clkgen_pkg::OUT_MCK: out_nxt = mck_lvl_r;
      clkgen_pkg::OUT_MCK_INV: out_nxt = ~mck_lvl_r;
      clkgen_pkg::OUT_MCK_DIV2: out_nxt = mck_half_r;
      default: out_nxt = 1'b0;
    endcase
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      CLK_OUT_O <= 1'b0;
      CLK_OUT_OE_N <= 1'b1;
    end else begin
      CLK_OUT_O <= out_nxt;
      CLK_OUT_OE_N <= mode_r.out_dis;
    end
  end

  // ----------------------------------------------------------------
  // peripheral clock gates
  // ----------------------------------------------------------------
  logic [31:0] gate_r;

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      gate_r <= 32'h0000_0000;
    end else if (wr_take && AVS_ADDRESS == `OFS_GATE_ON) begin
      gate_r <= gate_r | (wdata & `PERIPH_VALID);
    end else if (wr_take && AVS_ADDRESS == `OFS_GATE_OFF) begin
      gate_r <= gate_r & ~(wdata & `PERIPH_VALID);
    end
  end

  // gating only drops enables, so a stopped peripheral keeps its state
  for (genvar i = 0; i < 32; i++) begin : g_gate
    always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
        PERIPH_CLK_EN[i] <= 1'b0;
      end else begin
        PERIPH_CLK_EN[i] <= mck_tick & gate_r[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // lock interrupt
  // ----------------------------------------------------------------
  logic mask_r;
  logic evt_r;

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      mask_r <= 1'b0;
    end else if (wr_take && AVS_ADDRESS == `OFS_IRQ_EN && wdata[`LOCK_BIT]) begin
      mask_r <= 1'b1;
    end else if (wr_take && AVS_ADDRESS == `OFS_IRQ_DIS && wdata[`LOCK_BIT]) begin
      mask_r <= 1'b0;
    end
  end

  // a lock event in the clearing cycle wins over the clear
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      evt_r <= 1'b0;
    end else if (lock_evt) begin
      evt_r <= 1'b1;
    end else if (wr_take && AVS_ADDRESS == `OFS_EVT_CLEAR && wdata[`LOCK_BIT]) begin
      evt_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  logic [31:0] rd_nxt;

  always_comb begin
    rd_nxt = 32'h0000_0000;
    case (AVS_ADDRESS)
      `OFS_CLK_STATE: rd_nxt = gate_r;
      `OFS_MODE: rd_nxt = mode_r;
      `OFS_LOCK_STATE: rd_nxt[`LOCK_BIT] = pll_locked;
      `OFS_IRQ_MASK: rd_nxt[`LOCK_BIT] = mask_r;
      `OFS_EVT_STATUS: rd_nxt[`LOCK_BIT] = evt_r;
      default: rd_nxt = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      rdata_r <= 32'h0000_0000;
    end else if (AVS_READ && wait_r) begin
      rdata_r <= rd_nxt;
    end
  end

  // ----------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      MCK_EN <= 1'b0;
      PLL_ON <= 1'b0;
      PLL_HIGH_RANGE <= 1'b0;
      PLL_LOCKED <= 1'b0;
      IRQ <= 1'b0;
    end else begin
      MCK_EN <= mck_tick;
      PLL_ON <= mode_r.mul != 11'h000;
      PLL_HIGH_RANGE <= mode_r.range;
      PLL_LOCKED <= pll_locked;
      IRQ <= evt_r & mask_r;
    end
  end

  assign AVS_WAITREQUEST = wait_r;
  assign AVS_READDATA = rdata_r;

endmodule // clkgen

// ### verilog/clkgen_map.svh
`ifndef CLKGEN_MAP_SVH
`define CLKGEN_MAP_SVH
`define OFS_GATE_ON 8'h10
`define OFS_GATE_OFF 8'h14
`define OFS_CLK_STATE 8'h1c
`define OFS_MODE 8'h20
`define OFS_LOCK_STATE 8'h30
`define OFS_IRQ_EN 8'h34
`define OFS_IRQ_DIS 8'h38
`define OFS_IRQ_MASK 8'h3c
`define OFS_EVT_STATUS 8'h40
`define OFS_EVT_CLEAR 8'h44
`define PERIPH_VALID 32'h0000_6ffc
`define MODE_RESET 32'h0000_0000
`define MODE_VALID 32'hff07_ffff
`define LOCK_BIT 0
`define SLOW_HZ 32768
`define CLK_HZ 100000000
`endif

// ### verilog/clkgen_pkg.sv
package clkgen_pkg;
  typedef struct packed {
    logic [7:0] lock_count;
    logic [4:0] unused;
    logic [10:0] mul;
    logic master_clock_source;
    logic out_dis;
    logic [1:0] out_src;
    logic range;
    logic [2:0] prescaler_select;
  } mode_s;
  typedef enum logic [1:0] {
    OUT_SLOW = 2'b00,
    OUT_MCK = 2'b01,
    OUT_MCK_INV = 2'b10,
    OUT_MCK_DIV2 = 2'b11
  } out_src_e;
  typedef enum logic [1:0] {
    LK_OFF = 2'b00,
    LK_COUNT = 2'b01,
    LK_DONE = 2'b10
  } lock_e;
endpackage
